// ---- logic/scq_pkg.sv ----
// Purpose: shared constants and carriers for the serial crc / audio config block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: all offsets, writable-register reset values and field positions live here except the prescaler divider, bits 7:0
package scq_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_TX_CRC = 8'h18;
  localparam logic [7:0] ADDR_AUDIO_CTL = 8'h1C;
  localparam logic [7:0] ADDR_AUDIO_PSC = 8'h20;
  localparam logic [7:0] ADDR_QUAD_CTL = 8'h80;
  localparam logic [7:0] ADDR_UNIT_CTL = 8'h00;
  localparam logic [7:0] ADDR_UNIT_STAT = 8'h08;
  localparam logic [7:0] ADDR_CRC_POLY = 8'h10;
  // unit control field positions
  localparam int CTL_CRC_EN_BIT = 13;
  localparam int CTL_FRAME16_BIT = 11;
  localparam int CTL_LSB_FIRST_BIT = 7;
  // status field position
  localparam int STAT_BUSY_BIT = 7;
  // audio control fields
  localparam int AC_FUNC_SEL_BIT = 11;
  localparam int AC_ENABLE_BIT = 10;
  localparam int AC_OPMODE_LSB = 8;
  localparam int AC_PCM_SYNC_BIT = 7;
  localparam int AC_STD_LSB = 4;
  localparam int AC_IDLE_CLOCK_POLARITY_BIT = 3;
  localparam int AC_DLEN_LSB = 1;
  localparam int AC_SLOT_LENGTH_BIT = 0;
  // prescaler fields
  localparam int PSC_MCK_OE_BIT = 9;
  localparam int PSC_ODD_BIT = 8;
  // quad control fields
  localparam int QC_DRV_BIT = 2;
  localparam int QC_READ_BIT = 1;
  localparam int QC_EN_BIT = 0;
  // reset values and writable masks
  localparam logic [31:0] RST_AUDIO_CTL = 32'h0000_0000;
  localparam logic [31:0] RST_AUDIO_PSC = 32'h0000_0002;
  localparam logic [31:0] RST_QUAD_CTL = 32'h0000_0000;
  localparam logic [31:0] RST_UNIT_CTL = 32'h0000_0000;
  localparam logic [15:0] RST_CRC_POLY = 16'h0007;
  localparam logic [31:0] MASK_AUDIO_CTL = 32'h0000_0FBF;
  localparam logic [31:0] MASK_AUDIO_PSC = 32'h0000_03FF;
  localparam logic [31:0] MASK_QUAD_CTL = 32'h0000_0007;
  localparam logic [31:0] MASK_UNIT_CTL = 32'h0000_2880;
  // audio operation modes
  typedef enum logic [1:0] {
    SCQ_SLV_TX = 2'h0,
    SCQ_SLV_RX = 2'h1,
    SCQ_MST_TX = 2'h2,
    SCQ_MST_RX = 2'h3
  } scq_opmode_e;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scq_req_s;
  // transmit bit stream from the shifter
  typedef struct packed {
    logic bit_val;
    logic bit_vld;
    logic busy;
  } scq_txbit_s;
endpackage

// ---- logic/scq_crc_acc.sv ----
// Purpose: serial crc accumulator, one bit per step
// Assumes: bits arrive in shifted order on the wire
// Notes: crc8 uses the low byte of poly, crc16 all sixteen bits
`timescale 1ns/100ps
module scq_crc_acc (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic bit_i,
  input wire logic wide_i,
  input wire logic [15:0] poly_i,
  output logic [15:0] crc_o
);
  logic [15:0] crc_q; // running remainder
  logic fb; // feedback tap

  // feedback picks the msb of the active width
  always_comb begin
    fb = bit_i ^ (wide_i ? crc_q[15] : crc_q[7]);
  end

  // shift one bit; clear wins since it restarts the sum
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i) begin
      crc_q <= 16'h0000;
    end else if (step_i) begin
      if (wide_i) begin
        crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? poly_i : 16'h0000);
      end else begin
        crc_q <= {8'h00, crc_q[6:0], 1'b0} ^ (fb ? {8'h00, poly_i[7:0]} : 16'h0000);
      end
    end
  end

  assign crc_o = crc_q;
endmodule

// ---- logic/scq_top.sv ----
// Purpose: crc, audio config, audio prescaler and quad control of a serial port
// Assumes: shifter supplies transmitted bits in wire order and its busy level
// Notes: registers reached over a simple strobe port, read data one cycle later
// Operation
// - accumulate tx crc while crc enabled
// - crc8 in low byte, crc16 for wide
// - crc updated after every shifted bit
// - bit order changes the crc result
// - clear crc on enable and reset
// - bit 11 picks serial or audio
// - bit 10 enables audio, audio mode only
// - bits 9:8 audio operation mode
// - bit 7 pcm sync, pcm only
// - bits 5:4 audio standard select
// - bit 3 idle clock polarity
// - data length and channel length fields
// - prescaler bit 9 master clock output
// - divide by div times two plus odd
// - drive io2 io3 high single wire
// - quad direction bit changes when idle; writes land even while busy
// - quad enable changes when idle; writes land even while busy
// - quad bits on first instance only
// - busy flag while frame shifting
// - crc enable control bit
// - frame width control bit
// - bit order control bit
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module scq_top #(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic tx_bit_i,
  input wire logic tx_bit_vld_i,
  input wire logic shift_busy_i,
  output logic crc_calc_enable_o,
  output logic frame_width_select_o,
  output logic lsb_first_select_o,
  output logic transfer_busy_flag_o,
  output logic audio_function_select_o,
  output logic audio_enable_o,
  output logic [1:0] audio_operation_mode_o,
  output logic pcm_sync_length_o,
  output logic [1:0] audio_standard_select_o,
  output logic [1:0] sample_length_o,
  output logic slot_length_o,
  output logic audio_master_clock_pin_o,
  output logic audio_master_clock_pin_oe_o,
  output logic audio_bit_clock_pin_o,
  output logic audio_bit_clock_pin_oe_o,
  output logic quad_wire_enable_o,
  output logic quad_read_select_o,
  output logic io2_o,
  output logic io2_oe_o,
  output logic io3_o,
  output logic io3_oe_o
);
  scq_pkg::scq_req_s req; // bundled register request
  scq_pkg::scq_txbit_s txb; // bundled shifter stream
  logic [31:0] unit_ctl_q; // crc enable, frame width, bit order
  logic [31:0] audio_ctl_q; // audio control
  logic [31:0] audio_psc_q; // audio prescaler
  logic [31:0] quad_ctl_q; // quad control
  logic [15:0] crc_poly_q; // crc polynomial
  logic [31:0] rdata_q; // read data register
  logic [15:0] tx_crc; // accumulator result
  logic crc_clear; // restart pulse
  logic crc_en_set; // crc enable written 0 to 1
  logic [8:0] psc_cnt_q; // prescaler counter
  logic [8:0] real_div; // div * 2 + odd
  logic mck_q; // master clock toggle
  logic bck_q; // bit clock toggle
  logic busy_q; // registered busy level
  logic master_on; // master audio running
  logic wr_ctl; // write to unit control
  logic wr_ac; // write to audio control
  logic wr_psc; // write to prescaler
  logic wr_qc; // write to quad control
  logic wr_poly; // write to polynomial

  // bundle ports into carriers
  always_comb begin
    req.addr = reg_addr_i;
    req.wdata = reg_wdata_i;
    req.wr = reg_wr_i;
    req.rd = reg_rd_i;
    txb.bit_val = tx_bit_i;
    txb.bit_vld = tx_bit_vld_i;
    txb.busy = shift_busy_i;
  end

  // write decode
  always_comb begin
    wr_ctl = req.wr && (req.addr == scq_pkg::ADDR_UNIT_CTL);
    wr_ac = req.wr && (req.addr == scq_pkg::ADDR_AUDIO_CTL);
    wr_psc = req.wr && (req.addr == scq_pkg::ADDR_AUDIO_PSC);
    wr_qc = req.wr && (req.addr == scq_pkg::ADDR_QUAD_CTL) && FIRST_INSTANCE;
    wr_poly = req.wr && (req.addr == scq_pkg::ADDR_CRC_POLY);
  end

  // unit control bits steering crc and frame shape
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      unit_ctl_q <= scq_pkg::RST_UNIT_CTL;
    end else if (wr_ctl) begin
      unit_ctl_q <= req.wdata & scq_pkg::MASK_UNIT_CTL;
    end
  end

  // polynomial register, shared by crc8 and crc16
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      crc_poly_q <= scq_pkg::RST_CRC_POLY;
    end else if (wr_poly) begin
      crc_poly_q <= req.wdata[15:0];
    end
  end

  // audio control; software keeps it stable while audio runs
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      audio_ctl_q <= scq_pkg::RST_AUDIO_CTL;
    end else if (wr_ac) begin
      audio_ctl_q <= req.wdata & scq_pkg::MASK_AUDIO_CTL;
    end
  end

  // prescaler register, reset gives div of 2
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      audio_psc_q <= scq_pkg::RST_AUDIO_PSC;
    end else if (wr_psc) begin
      audio_psc_q <= req.wdata & scq_pkg::MASK_AUDIO_PSC;
    end
  end

  // quad control; software only writes while busy is clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      quad_ctl_q <= scq_pkg::RST_QUAD_CTL;
    end else if (wr_qc) begin
      quad_ctl_q <= req.wdata & scq_pkg::MASK_QUAD_CTL;
    end
  end

  // crc restarts on the enable rising so a fresh run starts at zero
  always_comb begin
    crc_en_set = wr_ctl && req.wdata[scq_pkg::CTL_CRC_EN_BIT] && !unit_ctl_q[scq_pkg::CTL_CRC_EN_BIT];
    crc_clear = crc_en_set;
  end

  // accumulator steps per wire bit, so bit order shapes the result
  scq_crc_acc u_crc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(crc_clear),
    .step_i(txb.bit_vld && unit_ctl_q[scq_pkg::CTL_CRC_EN_BIT]),
    .bit_i(txb.bit_val),
    .wide_i(unit_ctl_q[scq_pkg::CTL_FRAME16_BIT]),
    .poly_i(crc_poly_q),
    .crc_o(tx_crc)
  );

  // busy flag follows the shifter, registered once
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= txb.busy;
    end
  end

  // read mux, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.addr)
        scq_pkg::ADDR_UNIT_CTL: rdata_q <= unit_ctl_q;
        scq_pkg::ADDR_UNIT_STAT: rdata_q <= {24'h000000, busy_q, 7'h00};
        scq_pkg::ADDR_CRC_POLY: rdata_q <= {16'h0000, crc_poly_q};
        scq_pkg::ADDR_TX_CRC: begin
          // crc8 lives in the low byte only
          rdata_q <= {16'h0000, unit_ctl_q[scq_pkg::CTL_FRAME16_BIT] ? tx_crc[15:8] : 8'h00,
                      tx_crc[7:0]};
        end
        scq_pkg::ADDR_AUDIO_CTL: rdata_q <= audio_ctl_q;
        scq_pkg::ADDR_AUDIO_PSC: rdata_q <= audio_psc_q;
        scq_pkg::ADDR_QUAD_CTL: rdata_q <= quad_ctl_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // audio runs only when selected and enabled; enable ignored in serial mode
  always_comb begin
    master_on = audio_ctl_q[scq_pkg::AC_FUNC_SEL_BIT] && audio_ctl_q[scq_pkg::AC_ENABLE_BIT] &&
                audio_ctl_q[scq_pkg::AC_OPMODE_LSB + 1];
    real_div = {audio_psc_q[7:0], audio_psc_q[scq_pkg::PSC_ODD_BIT]};
  end

  // prescaler: master clock toggles on each half period of the real divider
  // odd divides give an uneven duty, an accepted trade for a single counter
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !master_on) begin
      psc_cnt_q <= 9'h000;
      mck_q <= 1'b0;
    end else if (psc_cnt_q >= real_div - 9'h001) begin
      psc_cnt_q <= 9'h000;
      mck_q <= 1'b1;
    end else begin
      psc_cnt_q <= psc_cnt_q + 9'h001;
      mck_q <= (psc_cnt_q + 9'h001) < {1'b0, real_div[8:1]};
    end
  end

  // bit clock: one half period per real-divide period, idle at polarity
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !master_on) begin
      bck_q <= audio_ctl_q[scq_pkg::AC_IDLE_CLOCK_POLARITY_BIT];
    end else if (psc_cnt_q >= real_div - 9'h001) begin
      bck_q <= ~bck_q;
    end
  end

  // register-driven outputs to the rest of the unit
  always_comb begin
    crc_calc_enable_o = unit_ctl_q[scq_pkg::CTL_CRC_EN_BIT];
    frame_width_select_o = unit_ctl_q[scq_pkg::CTL_FRAME16_BIT];
    lsb_first_select_o = unit_ctl_q[scq_pkg::CTL_LSB_FIRST_BIT];
    transfer_busy_flag_o = busy_q;
    audio_function_select_o = audio_ctl_q[scq_pkg::AC_FUNC_SEL_BIT];
    audio_enable_o = audio_ctl_q[scq_pkg::AC_FUNC_SEL_BIT] && audio_ctl_q[scq_pkg::AC_ENABLE_BIT];
    audio_operation_mode_o = audio_ctl_q[scq_pkg::AC_OPMODE_LSB +: 2];
    // pcm sync only means something under the pcm standard
    pcm_sync_length_o = (audio_ctl_q[scq_pkg::AC_STD_LSB +: 2] == 2'h3) &&
                        audio_ctl_q[scq_pkg::AC_PCM_SYNC_BIT];
    audio_standard_select_o = audio_ctl_q[scq_pkg::AC_STD_LSB +: 2];
    sample_length_o = audio_ctl_q[scq_pkg::AC_DLEN_LSB +: 2];
    slot_length_o = audio_ctl_q[scq_pkg::AC_SLOT_LENGTH_BIT];
  end

  // audio pins: master clock gated by its enable, bit clock driven in master
  always_comb begin
    audio_master_clock_pin_o = mck_q;
    audio_master_clock_pin_oe_o = audio_psc_q[scq_pkg::PSC_MCK_OE_BIT] && audio_ctl_q[scq_pkg::AC_FUNC_SEL_BIT];
    audio_bit_clock_pin_o = bck_q;
    audio_bit_clock_pin_oe_o = audio_ctl_q[scq_pkg::AC_FUNC_SEL_BIT] && audio_ctl_q[scq_pkg::AC_OPMODE_LSB + 1];
  end

  // quad lines: upper lines held high in single-wire mode when asked
  always_comb begin
    quad_wire_enable_o = quad_ctl_q[scq_pkg::QC_EN_BIT];
    quad_read_select_o = quad_ctl_q[scq_pkg::QC_READ_BIT];
    io2_o = 1'b1;
    io3_o = 1'b1;
    io2_oe_o = !quad_ctl_q[scq_pkg::QC_EN_BIT] && quad_ctl_q[scq_pkg::QC_DRV_BIT];
    io3_oe_o = !quad_ctl_q[scq_pkg::QC_EN_BIT] && quad_ctl_q[scq_pkg::QC_DRV_BIT];
  end

  assign reg_rdata_o = rdata_q;
endmodule

// ---- verif/scq_props.sv ----
// Purpose: port-level properties of the serial crc / audio config block
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto every scq_top instance
`timescale 1ns/100ps
module scq_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic shift_busy_i,
  input logic transfer_busy_flag_o,
  input logic audio_function_select_o,
  input logic audio_enable_o,
  input logic [1:0] audio_operation_mode_o,
  input logic pcm_sync_length_o,
  input logic [1:0] audio_standard_select_o,
  input logic audio_master_clock_pin_o,
  input logic audio_master_clock_pin_oe_o,
  input logic audio_bit_clock_pin_oe_o,
  input logic quad_wire_enable_o,
  input logic io2_o,
  input logic io2_oe_o,
  input logic io3_oe_o
);
  // all checks share the one clock and its reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  busy_follow_a: assert property (1'b1 |=> transfer_busy_flag_o == $past(shift_busy_i))
    else $error("busy flag does not follow the shifter");
  audio_gate_a: assert property (audio_enable_o |-> audio_function_select_o)
    else $error("audio enabled outside audio mode");
  pcm_only_a: assert property (pcm_sync_length_o |-> audio_standard_select_o == 2'h3)
    else $error("pcm sync shown outside pcm standard");
  mck_oe_a: assert property (audio_master_clock_pin_oe_o |-> audio_function_select_o)
    else $error("master clock driven outside audio mode");
  bck_oe_a: assert property (audio_bit_clock_pin_oe_o == (audio_function_select_o && audio_operation_mode_o[1]))
    else $error("bit clock drive does not match master mode");
  mck_idle_a: assert property (!audio_enable_o [*2] |-> !audio_master_clock_pin_o)
    else $error("master clock runs while audio is off");
  io_drive_a: assert property (io2_oe_o |-> io2_o && !quad_wire_enable_o)
    else $error("upper lines driven wrongly");
  io_pair_a: assert property (io2_oe_o == io3_oe_o)
    else $error("upper line enables differ");
endmodule

bind scq_top scq_props u_props (.clk_i, .rst_b_i, .shift_busy_i, .transfer_busy_flag_o, .audio_function_select_o,
  .audio_enable_o, .audio_operation_mode_o, .pcm_sync_length_o, .audio_standard_select_o, .audio_master_clock_pin_o,
  .audio_master_clock_pin_oe_o, .audio_bit_clock_pin_oe_o, .quad_wire_enable_o, .io2_o, .io2_oe_o, .io3_oe_o);

// ---- verif/scq_shifter_model.sv ----
// Purpose: stands in for the shifter feeding transmitted bits
// Assumes: frame width and bit order follow the block's own controls
// Notes: bit line wanders between frames so a stale value never matches
`timescale 1ns/100ps
module scq_shifter_model (
  input wire logic clk_i,
  input wire logic wide_i,
  input wire logic lsb_i,
  output logic bit_o,
  output logic vld_o,
  output logic busy_o
);
  initial begin
    bit_o = 1'b0;
    vld_o = 1'b0;
    busy_o = 1'b0;
  end
  // one bit per cycle in wire order, busy around the whole frame
  task automatic send_frame(input logic [15:0] d);
    int n;
    int i;
    @(posedge clk_i);
    // width read after the edge so a control write just before it has landed
    n = wide_i ? 16 : 8;
    busy_o <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      vld_o <= 1'b1;
      bit_o <= lsb_i ? d[i] : d[n-1-i];
    end
    @(posedge clk_i);
    vld_o <= 1'b0;
    busy_o <= 1'b0;
    bit_o <= ~bit_o;
  endtask
endmodule

// ---- verif/tb_scq_top.sv ----
// Purpose: self-checking bench for the serial crc / audio config block
// Assumes: register reads answer one cycle after the strobe
// Notes: random traffic from a fixed seed, corner cases mixed in
`timescale 1ns/100ps
module tb_scq_top;
  logic clk_i = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rdata;
  logic tx_bit, tx_vld, shift_busy, fw, lf, afs, aen, pcm, slen, chl, mck, mck_oe, bck, qen, quad_read_select, io2_oe, io3_oe, cen;
  logic [1:0] opm, std, dlen;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int p;
  logic [31:0] v;
  logic [15:0] crc;
  logic [7:0] div;
  // dut and the shifter stand-in
  scq_top dut (.clk_i(clk_i), .rst_b_i(rst_b), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .tx_bit_i(tx_bit), .tx_bit_vld_i(tx_vld), .shift_busy_i(shift_busy),
    .crc_calc_enable_o(cen), .frame_width_select_o(fw), .lsb_first_select_o(lf), .transfer_busy_flag_o(),
    .audio_function_select_o(afs), .audio_enable_o(aen), .audio_operation_mode_o(opm), .pcm_sync_length_o(pcm),
    .audio_standard_select_o(std), .sample_length_o(dlen), .slot_length_o(chl), .audio_master_clock_pin_o(mck),
    .audio_master_clock_pin_oe_o(mck_oe), .audio_bit_clock_pin_o(bck), .audio_bit_clock_pin_oe_o(),
    .quad_wire_enable_o(qen), .quad_read_select_o(quad_read_select), .io2_o(), .io2_oe_o(io2_oe), .io3_o(), .io3_oe_o(io3_oe));
  scq_shifter_model shifter (.clk_i(clk_i), .wide_i(fw), .lsb_i(lf), .bit_o(tx_bit), .vld_o(tx_vld),
    .busy_o(shift_busy));
  always #25 clk_i = ~clk_i;
  // hang guard, far above the length of the sequence
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  // read data sampled in the one cycle it stands
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 check(name, rdata, exp);
  endtask
  // bench's own serial crc, wire order taken from the bit order flag
  function automatic logic [15:0] crc_calc(input logic [15:0] c, input logic [15:0] d, input logic wide,
    input logic lsb);
    logic fb;
    int i;
    int n;
    n = wide ? 16 : 8;
    for (i = 0; i < n; i++) begin
      fb = (wide ? c[15] : c[7]) ^ (lsb ? d[i] : d[n-1-i]);
      c = {c[14:0], 1'b0} ^ (fb ? scq_pkg::RST_CRC_POLY : 16'h0);
      if (!wide) c[15:8] = 8'h00;
    end
    return c;
  endfunction
  // cycles between two rising edges of the chosen audio clock
  task automatic rise_gap(input bit bitclk, output int gap);
    logic prev;
    logic cur;
    int k;
    int first;
    first = -1;
    gap = -1;
    prev = 1'b1;
    for (k = 0; k < 1200 && gap < 0; k++) begin
      @(posedge clk_i);
      #1 cur = bitclk ? bck : mck;
      if (cur && !prev) begin
        if (first >= 0) gap = k - first;
        first = k;
      end
      prev = cur;
    end
  endtask
  initial begin
    v = $urandom(57898);
    repeat (5) @(posedge clk_i);
    rst_b <= 1'b1;
    rdchk("tx crc", scq_pkg::ADDR_TX_CRC, 32'h0);
    rdchk("audio ctl", scq_pkg::ADDR_AUDIO_CTL, scq_pkg::RST_AUDIO_CTL);
    rdchk("prescaler", scq_pkg::ADDR_AUDIO_PSC, scq_pkg::RST_AUDIO_PSC);
    rdchk("quad ctl", scq_pkg::ADDR_QUAD_CTL, scq_pkg::RST_QUAD_CTL);
    wr(8'h44, 32'hFFFF_FFFF);
    wr(scq_pkg::ADDR_TX_CRC, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h44, 32'h0);
    rdchk("tx crc ro", scq_pkg::ADDR_TX_CRC, 32'h0);
    // audio setup written while the audio enable stays off
    repeat (6) begin
      v = $urandom & 32'hFFFF_FBFF; // enable kept clear while fields change
      // reserved length swapped for 32 bits, channel widened to hold the data
      if (v[2:1] == 2'h3) v[2:1] = 2'h2;
      if (v[2:1] != 2'h0) v[0] = 1'b1;
      wr(scq_pkg::ADDR_AUDIO_CTL, v);
      rdchk("audio ctl", scq_pkg::ADDR_AUDIO_CTL, v & scq_pkg::MASK_AUDIO_CTL);
      check("func sel", 32'(afs), 32'(v[11]));
      check("opmode", 32'(opm), 32'(v[9:8]));
      check("pcm sync", 32'(pcm), 32'(v[7] && v[5:4] == 2'h3));
      check("standard", 32'(std), 32'(v[5:4]));
      check("idle clk", 32'(bck), 32'(v[3]));
      check("lengths", 32'({dlen, chl}), 32'(v[2:0]));
    end
    // quad control with the port idle
    repeat (6) begin
      v = $urandom & 32'h7;
      wr(scq_pkg::ADDR_QUAD_CTL, v);
      rdchk("quad ctl", scq_pkg::ADDR_QUAD_CTL, v);
      check("quad en", 32'(qen), 32'(v[0]));
      check("quad rd", 32'(quad_read_select), 32'(v[1]));
      check("io2 oe", 32'(io2_oe), 32'(v[2] && !v[0]));
      check("io3 oe", 32'(io3_oe), 32'(v[2] && !v[0]));
    end
    // crc over random frames, width and order drawn each time
    repeat (10) begin
      v = $urandom;
      wr(scq_pkg::ADDR_UNIT_CTL, 32'h0);
      wr(scq_pkg::ADDR_UNIT_CTL, 32'h2000 | (32'(v[0]) << 11) | (32'(v[1]) << 7));
      crc = crc_calc(16'h0, v[31:16], v[0], v[1]);
      shifter.send_frame(v[31:16]);
      check("crc en", 32'(cen), 32'h1);
      rdchk("tx crc", scq_pkg::ADDR_TX_CRC, {16'h0, crc});
    end
    // back-to-back frame keeps accumulating
    shifter.send_frame(v[15:0]);
    crc = crc_calc(crc, v[15:0], v[0], v[1]);
    rdchk("tx crc acc", scq_pkg::ADDR_TX_CRC, {16'h0, crc});
    wr(scq_pkg::ADDR_UNIT_CTL, 32'(v[0]) << 11);
    shifter.send_frame(16'hA5C3);
    rdchk("tx crc off", scq_pkg::ADDR_TX_CRC, {16'h0, crc});
    wr(scq_pkg::ADDR_UNIT_CTL, 32'h2000);
    rdchk("tx crc clr", scq_pkg::ADDR_TX_CRC, 32'h0);
    // prescaler programmed while off, then master transmit switched on
    repeat (4) begin
      v = $urandom;
      div = 8'h01 + 8'(v[3:0]); // never zero
      wr(scq_pkg::ADDR_AUDIO_CTL, 32'h0);
      wr(scq_pkg::ADDR_AUDIO_PSC, {22'h0, v[5], v[4], div});
      wr(scq_pkg::ADDR_AUDIO_CTL, 32'hE00 | (32'(v[6]) << 3));
      // the enabling write lands at this edge, so look once it has settled
      #1 check("mck oe", 32'(mck_oe), 32'(v[5]));
      check("audio en", 32'(aen), 32'h1);
      rise_gap(1'b0, p);
      check("mck period", 32'(p), 32'(div) * 2 + 32'(v[4]));
      rise_gap(1'b1, p);
      check("bck period", 32'(p), (32'(div) * 2 + 32'(v[4])) * 2);
    end
    wr(scq_pkg::ADDR_AUDIO_CTL, 32'h0);
    give_verdict();
  end
endmodule
